// >>> rtl/fir_defs.vh
// Constants for the channel-A equaliser filter coefficient block.
`ifndef FIR_DEFS_VH
`define FIR_DEFS_VH
// Register indices; the byte address is four times the index.
`define IDX_TAP_ONE 14'h0418
`define IDX_TAP_TWO 14'h041a
`define IDX_TAP_THREE 14'h041c
`define IDX_TAP_FOUR 14'h041e
`define IDX_TAP_FIVE 14'h0420
`define IDX_TAP_SIX 14'h0423
`define IDX_TAP_SEVEN 14'h0425
`define IDX_TAP_EIGHT 14'h0427
`define IDX_TAP_NINE 14'h0429
`define IDX_FILTER_CFG 14'h0400
`define IDX_LINK_CTRL 14'h0200
`define IDX_STATUS 14'h0201
// Decoder selections beyond the nine taps.
`define SEL_CFG 5'h09
`define SEL_LINK 5'h0a
`define SEL_STATUS 5'h0b
`define SEL_NONE 5'h1f
// Filter geometry.
`define NUM_TAPS 9
`define CENTRE_TAP 4
// Bytes of the widest coefficient register that strobes can reach.
`define COEF_BYTES 3
`define SIDE_MASK 24'h00ffff
`define CENTRE_MASK 24'hffffff
// Configuration field positions.
`define MODE_LO 0
`define MODE_HI 1
`define SCW_LO 2
`define SCW_HI 4
`define MERGE_BIT 5
`define MODE_BYPASS 2'h0
`define MODE_ENABLE 2'h2
`define SCW_MAX 3'h6
// Fixed-point scaling: coefficient LSB is two to the minus sixteen.
`define FRAC_BITS 16
`define SAT_HI 36'h0000007ff
`define SAT_LO 36'hffffff800
// Bus answers.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> rtl/fir_tap_mac.v
// One weighted tap product of the equaliser filter.
`timescale 1ns/1ps
module fir_tap_mac (
	// Operands.
	input wire [17:0] coef_in,
	input wire [11:0] sample_in,
	input wire [2:0] shift_in,
	// Result.
	output wire [35:0] product_out
);
	// Raw signed product, 30 bits wide.
	wire signed [29:0] raw_prod;
	// Product widened to the accumulator width.
	wire signed [35:0] wide_prod;

	assign raw_prod = $signed(coef_in) * $signed(sample_in);
	assign wide_prod = {{6{raw_prod[29]}}, raw_prod};
	// The shift raises the coefficient LSB weight.
	assign product_out = wide_prod <<< shift_in;
endmodule // fir_tap_mac

// >>> rtl/fir_coefficient_taps_chan_a.v
// Channel-A equaliser filter with its coefficient registers on AXI4-Lite.
// Operation
// - Side taps: 12-bit signed, bits 15:12 reserved.
// - Register tap two weights second tap.
// - Register tap three weights third tap.
// - Register tap four weights fourth tap.
// - Centre tap five: 18-bit signed, 24-bit register.
// - Nine-tap filter, fifth tap is centre.
// - All coefficient bits reset to zero.
// - Mode 0 bypasses, mode 2 enables filter.
// - Side LSB weight is two^(weight minus 16).
// - Merge bit joins both paths into one stream.
`timescale 1ns/1ps
`include "fir_defs.vh"
module fir_coefficient_taps_chan_a (
	// Clock and reset.
	input wire clk_in,
	input wire nrst_in,
	// AXI4-Lite write address and data.
	input wire [15:0] s_axi_awaddr_in,
	input wire s_axi_awvalid_in,
	output reg s_axi_awready_out,
	input wire [31:0] s_axi_wdata_in,
	input wire [3:0] s_axi_wstrb_in,
	input wire s_axi_wvalid_in,
	output reg s_axi_wready_out,
	// AXI4-Lite write response.
	output reg s_axi_bvalid_out,
	output reg [1:0] s_axi_bresp_out,
	input wire s_axi_bready_in,
	// AXI4-Lite read.
	input wire [15:0] s_axi_araddr_in,
	input wire s_axi_arvalid_in,
	output reg s_axi_arready_out,
	output reg s_axi_rvalid_out,
	output reg [31:0] s_axi_rdata_out,
	output reg [1:0] s_axi_rresp_out,
	input wire s_axi_rready_in,
	// Converter sample stream.
	input wire [11:0] sample_a_in,
	input wire [11:0] sample_b_in,
	input wire sample_valid_in,
	// Filtered stream and link control.
	output reg [11:0] filt_sample_out,
	output reg filt_valid_out,
	output reg serial_link_enable_out
);
	//--------------------------------------------------------------
	// Declarations
	//--------------------------------------------------------------
	reg [23:0] coef_reg [0:8]; // Coefficients, tap one first.
	reg [11:0] line_reg [0:8]; // Delay line, newest sample first.
	reg [7:0] cfg_reg; // Mode, side weight, merge and reserved bits.
	reg [15:0] aw_addr_reg; // Latched write address.
	reg aw_full_reg; // Write address held.
	reg [31:0] w_data_reg; // Latched write data.
	reg [3:0] w_strb_reg; // Latched byte strobes.
	reg w_full_reg; // Write data held.
	reg phase_reg; // Merged stream path select, high picks path B.
	reg line_valid_reg; // Delay line moved in the previous cycle.
	wire [4:0] wr_sel; // Decoded write target.
	wire [4:0] rd_sel; // Decoded read target.
	wire wr_fire; // Write performed this cycle.
	wire [1:0] mode; // Filter mode field.
	wire merge; // Merge bit.
	wire [2:0] scw_raw; // Side weight field as written.
	wire [2:0] scw; // Side weight limited to its range.
	wire [11:0] new_sample; // Sample entering the delay line.
	wire [35:0] prod [0:8]; // Weighted tap products.
	reg [35:0] acc; // Sum of all products.
	reg [35:0] scaled; // Sum scaled to sample units.
	reg [11:0] sat; // Saturated filter result.
	reg [31:0] rd_word; // Read data for the decoded address.
	integer k;
	// Maps a byte address onto a register selection.
	function [4:0] decode;
		input [15:0] addr;
		begin
			if (addr[1:0] != 2'h0) begin
				decode = `SEL_NONE;
			end else begin
				case (addr[15:2])
					`IDX_TAP_ONE: decode = 5'h00;
					`IDX_TAP_TWO: decode = 5'h01;
					`IDX_TAP_THREE: decode = 5'h02;
					`IDX_TAP_FOUR: decode = 5'h03;
					`IDX_TAP_FIVE: decode = 5'h04;
					`IDX_TAP_SIX: decode = 5'h05;
					`IDX_TAP_SEVEN: decode = 5'h06;
					`IDX_TAP_EIGHT: decode = 5'h07;
					`IDX_TAP_NINE: decode = 5'h08;
					`IDX_FILTER_CFG: decode = `SEL_CFG;
					`IDX_LINK_CTRL: decode = `SEL_LINK;
					`IDX_STATUS: decode = `SEL_STATUS;
					default: decode = `SEL_NONE;
				endcase
			end
		end
	endfunction
	assign wr_sel = decode(aw_addr_reg);
	assign rd_sel = decode(s_axi_araddr_in);
	assign wr_fire = aw_full_reg & w_full_reg & ~s_axi_bvalid_out;
	assign mode = cfg_reg[`MODE_HI:`MODE_LO];
	assign merge = cfg_reg[`MERGE_BIT];
	assign scw_raw = cfg_reg[`SCW_HI:`SCW_LO];
	// Weights above the range are held at the largest legal one.
	assign scw = (scw_raw > `SCW_MAX) ? `SCW_MAX : scw_raw;
	// Merged operation takes path A and path B on alternate beats.
	assign new_sample = (merge & phase_reg) ? sample_b_in
		: sample_a_in;
	//--------------------------------------------------------------
	// Write channel
	//--------------------------------------------------------------
	// Address and data are taken in either order, then the write runs.
	always @(posedge clk_in) begin
		if (!nrst_in) begin
			aw_addr_reg <= 16'h0000;
			aw_full_reg <= 1'b0;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			w_full_reg <= 1'b0;
			s_axi_awready_out <= 1'b1;
			s_axi_wready_out <= 1'b1;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid_in & s_axi_awready_out) begin
				aw_addr_reg <= s_axi_awaddr_in;
				aw_full_reg <= 1'b1;
				s_axi_awready_out <= 1'b0;
			end
			if (s_axi_wvalid_in & s_axi_wready_out) begin
				w_data_reg <= s_axi_wdata_in;
				w_strb_reg <= s_axi_wstrb_in;
				w_full_reg <= 1'b1;
				s_axi_wready_out <= 1'b0;
			end
			if (wr_fire) begin
				// Unmapped or misaligned addresses answer with an error.
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out <= (wr_sel == `SEL_NONE) ? `RESP_SLVERR
					: `RESP_OKAY;
			end
			if (s_axi_bvalid_out & s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				s_axi_awready_out <= 1'b1;
				s_axi_wready_out <= 1'b1;
			end
		end
	end
	// Configuration and link control registers.
	always @(posedge clk_in) begin
		if (!nrst_in) begin
			cfg_reg <= 8'h00;
			serial_link_enable_out <= 1'b0;
		end else if (wr_fire) begin
			// Changes apply at once; software keeps the link off meanwhile.
			if ((wr_sel == `SEL_CFG) & w_strb_reg[0]) begin
				cfg_reg <= w_data_reg[7:0];
			end
			if ((wr_sel == `SEL_LINK) & w_strb_reg[0]) begin
				serial_link_enable_out <= w_data_reg[0];
			end
		end
	end
	//--------------------------------------------------------------
	// Coefficient storage and taps
	//--------------------------------------------------------------
	genvar i, j;
	generate
		for (i = 0; i < `NUM_TAPS; i = i + 1) begin : tap
			// Side taps keep 16 bits, the centre tap 24 bits.
			localparam [23:0] MASK = (i == `CENTRE_TAP) ? `CENTRE_MASK
				: `SIDE_MASK;
			// Coefficient operand, sign-extended to 18 bits.
			wire [17:0] coef_op;
			// Side taps carry the side weight, the centre none.
			wire [2:0] shift_op;
			// Write word: strobed bytes from the bus, the others kept.
			wire [23:0] wr_word;
			for (j = 0; j < `COEF_BYTES; j = j + 1) begin : lane
				assign wr_word[j*8 +: 8] = w_strb_reg[j]
					? w_data_reg[j*8 +: 8] : coef_reg[i][j*8 +: 8];
			end
			// Holds one coefficient, reserved bits included.
			always @(posedge clk_in) begin
				if (!nrst_in) begin
					coef_reg[i] <= 24'h000000;
				end else if (wr_fire && (wr_sel == i)) begin
					coef_reg[i] <= wr_word & MASK;
				end
			end
			// Shifts the delay line on each accepted sample.
			always @(posedge clk_in) begin
				if (!nrst_in) begin
					line_reg[i] <= 12'h000;
				end else if (sample_valid_in) begin
					line_reg[i] <= (i == 0) ? new_sample
						: line_reg[(i == 0) ? 0 : i - 1];
				end
			end
			if (i == `CENTRE_TAP) begin : centre
				assign coef_op = coef_reg[i][17:0];
				assign shift_op = 3'h0;
			end else begin : side
				assign coef_op = {{6{coef_reg[i][11]}},
					coef_reg[i][11:0]};
				assign shift_op = scw;
			end
			fir_tap_mac mac (
				.coef_in(coef_op),
				.sample_in(line_reg[i]),
				.shift_in(shift_op),
				.product_out(prod[i])
			);
		end
	endgenerate
	//--------------------------------------------------------------
	// Filter arithmetic
	//--------------------------------------------------------------
	// Sums the products, rescales and saturates to 12 bits.
	always @* begin
		acc = 36'h000000000;
		for (k = 0; k < `NUM_TAPS; k = k + 1) begin
			acc = acc + prod[k];
		end
		scaled = $signed(acc) >>> `FRAC_BITS;
		if ($signed(scaled) > $signed(`SAT_HI)) begin
			sat = 12'h7ff;
		end else if ($signed(scaled) < $signed(`SAT_LO)) begin
			sat = 12'h800;
		end else begin
			sat = scaled[11:0];
		end
	end
	// Output stage: filtered in mode 2, passed through otherwise.
	always @(posedge clk_in) begin
		if (!nrst_in) begin
			phase_reg <= 1'b0;
			line_valid_reg <= 1'b0;
			filt_sample_out <= 12'h000;
			filt_valid_out <= 1'b0;
		end else begin
			line_valid_reg <= sample_valid_in;
			if (sample_valid_in) begin
				phase_reg <= merge ? ~phase_reg : 1'b0;
			end
			filt_valid_out <= line_valid_reg;
			if (line_valid_reg) begin
				// Reserved modes behave as bypass.
				filt_sample_out <= (mode == `MODE_ENABLE) ? sat
					: line_reg[0];
			end
		end
	end
	//--------------------------------------------------------------
	// Read channel
	//--------------------------------------------------------------
	// Selects the word that a read returns.
	always @* begin
		rd_word = 32'h00000000;
		if (rd_sel < `NUM_TAPS) begin
			rd_word = {8'h00, coef_reg[rd_sel[3:0]]};
		end else if (rd_sel == `SEL_CFG) begin
			rd_word = {24'h000000, cfg_reg};
		end else if (rd_sel == `SEL_LINK) begin
			rd_word = {31'h00000000, serial_link_enable_out};
		end else if (rd_sel == `SEL_STATUS) begin
			rd_word = {30'h00000000, merge, (mode == `MODE_ENABLE)};
		end
	end
	// Takes one read address at a time and answers the next cycle.
	always @(posedge clk_in) begin
		if (!nrst_in) begin
			s_axi_arready_out <= 1'b1;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h00000000;
			s_axi_rresp_out <= `RESP_OKAY;
		end else if (s_axi_arvalid_in & s_axi_arready_out) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out <= 1'b1;
			s_axi_rdata_out <= rd_word;
			s_axi_rresp_out <= (rd_sel == `SEL_NONE) ? `RESP_SLVERR
				: `RESP_OKAY;
		end else if (s_axi_rvalid_out & s_axi_rready_in) begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_arready_out <= 1'b1;
		end
	end
endmodule // fir_coefficient_taps_chan_a

// >>> verif/coef_monitor.sv
// Checker of the equaliser block's stream and register bus.
`timescale 1ns/1ps
`include "fir_defs.vh"
module coef_monitor (
	// Clock and reset.
	input logic clk_in,
	input logic nrst_in,
	// Register bus.
	input logic [15:0] s_axi_awaddr_in,
	input logic s_axi_awvalid_in,
	input logic s_axi_awready_out,
	input logic [31:0] s_axi_wdata_in,
	input logic s_axi_wvalid_in,
	input logic s_axi_wready_out,
	input logic s_axi_bvalid_out,
	input logic [1:0] s_axi_bresp_out,
	input logic s_axi_bready_in,
	input logic [15:0] s_axi_araddr_in,
	input logic s_axi_arvalid_in,
	input logic s_axi_arready_out,
	input logic s_axi_rvalid_out,
	input logic [31:0] s_axi_rdata_out,
	// Stream and link.
	input logic [11:0] sample_a_in,
	input logic sample_valid_in,
	input logic [11:0] filt_sample_out,
	input logic filt_valid_out,
	input logic serial_link_enable_out
);
	// Last addresses and data taken, and the filter setup.
	logic [15:0] wa_reg, ra_reg;
	logic [31:0] wd_reg;
	logic [5:0] cfg_reg;
	wire ok_w = s_axi_bvalid_out && s_axi_bready_in && !s_axi_bresp_out[1];
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	// Follow accepted writes so mode-dependent checks know the setup.
	always @(posedge clk_in) begin
		if (s_axi_awvalid_in && s_axi_awready_out) wa_reg <= s_axi_awaddr_in;
		if (s_axi_wvalid_in && s_axi_wready_out) wd_reg <= s_axi_wdata_in;
		if (s_axi_arvalid_in && s_axi_arready_out) ra_reg <= s_axi_araddr_in;
		if (!nrst_in) cfg_reg <= 6'h00;
		else if (ok_w && wa_reg == {`IDX_FILTER_CFG, 2'h0})
			cfg_reg <= wd_reg[5:0];
	end
	AST_FILT_LAT: assert property (
		sample_valid_in |-> ##2 filt_valid_out) else $error("output late");
	AST_FILT_ONLY: assert property (
		filt_valid_out |-> $past(sample_valid_in, 2))
		else $error("output without a sample");
	AST_BYPASS: assert property (
		filt_valid_out && cfg_reg[1:0] != 2'h2 && !cfg_reg[5]
		|-> filt_sample_out == $past(sample_a_in, 2)) else $error("bypass");
	AST_RST_QUIET: assert property (
		!$past(nrst_in) |-> !(s_axi_bvalid_out || s_axi_rvalid_out
		|| filt_valid_out || serial_link_enable_out)) else $error("reset");
	AST_SIDE_WIDTH: assert property (
		s_axi_rvalid_out && ra_reg >= {`IDX_TAP_TWO, 2'h0}
		&& ra_reg <= {`IDX_TAP_FOUR, 2'h0}
		|-> s_axi_rdata_out[31:16] == 16'h0) else $error("side width");
	AST_CTR_WIDTH: assert property (
		s_axi_rvalid_out && ra_reg == {`IDX_TAP_FIVE, 2'h0}
		|-> s_axi_rdata_out[31:24] == 8'h0) else $error("centre width");
	AST_LINK: assert property (
		ok_w && wa_reg == {`IDX_LINK_CTRL, 2'h0}
		|=> serial_link_enable_out == wd_reg[0]) else $error("link bit");
	AST_RD_LAT: assert property (
		s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("read answer late");
endmodule // coef_monitor

// >>> verif/sample_source.sv
// Converter sample source feeding both paths of the filter.
`timescale 1ns/1ps
module sample_source (
	// Clock, reset and run control.
	input wire clk_in,
	input wire nrst_in,
	input wire run_in,
	// Sample stream.
	output logic [11:0] a_out,
	output logic [11:0] b_out,
	output logic valid_out
);
	// Pseudo-random state; data keeps changing even when not valid.
	logic [31:0] lfsr_reg = 32'h7b51;
	// Next state of the pseudo-random generator.
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], ^(s & 32'h80200003)};
	endfunction
	initial begin
		a_out = 12'h0;
		b_out = 12'h0;
		valid_out = 1'h0;
	end
	// Step the state and present both paths, with random gaps.
	always @(posedge clk_in) begin
		lfsr_reg <= lfsr_next(lfsr_reg);
		valid_out <= nrst_in && run_in && lfsr_reg[3:0] != 4'h0;
		a_out <= lfsr_reg[11:0];
		b_out <= lfsr_reg[23:12];
	end
endmodule // sample_source

// >>> verif/tb_top.sv
// Self-checking bench of the channel-A equaliser coefficient block.
`timescale 1ns/1ps
`include "fir_defs.vh"
module tb_top;
	// ----
	// Signals and expectation state.
	// ----
	logic clk_in = 1'h0;
	logic nrst_in = 1'h0;
	logic run_reg = 1'h0;
	logic [15:0] s_axi_awaddr_in = 16'h0, s_axi_araddr_in = 16'h0;
	logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out;
	logic [3:0] s_axi_wstrb_in = 4'hf;
	logic s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0;
	logic s_axi_bready_in = 1'h0, s_axi_arvalid_in = 1'h0;
	logic s_axi_rready_in = 1'h0, s_axi_awready_out, s_axi_wready_out;
	logic s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
	logic filt_valid_out, serial_link_enable_out, sample_valid_in;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
	logic [11:0] sample_a_in, sample_b_in, filt_sample_out;
	int err_total = 0, checks_done = 0, mode = 0, scw = 0, merge = 0;
	bit selb = 0;
	longint h[9];
	logic [1:0] bq[$];
	logic [33:0] rq[$], re;
	logic [11:0] sq[$];
	logic [15:0] ad[4] = '{{`IDX_TAP_TWO, 2'h0}, {`IDX_TAP_THREE, 2'h0},
		{`IDX_TAP_FOUR, 2'h0}, {`IDX_TAP_FIVE, 2'h0}};
	logic [31:0] cv[4] = '{32'hf800, 32'h7ff, 32'ha123, 32'hfd0000};
	longint cs[4] = '{-2048, 2047, 291, 65536};
	logic [5:0] cf[6] = '{6'h00, 6'h01, 6'h23, 6'h02, 6'h3a, 6'h1e};
	always #2.5 clk_in = ~clk_in;
	fir_coefficient_taps_chan_a u_fir_coefficient_taps_chan_a (.*);
	sample_source u_sample_source (.clk_in(clk_in), .nrst_in(nrst_in),
		.run_in(run_reg), .a_out(sample_a_in), .b_out(sample_b_in),
		.valid_out(sample_valid_in));
	// ----
	// Checking and bus tasks.
	// ----
	task automatic chk(input string nm, input logic [31:0] s, e);
		checks_done++;
		if (s !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// A wait that ran out of cycles ends the run.
	task tmo(input int k);
		if (k >= 60) begin
			err_total++;
			$display("ERROR wait expected answer seen none");
			test_done;
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d,
		input logic [1:0] er);
		bit ap, wp;
		int k;
		bq.push_back(er);
		ap = 1;
		wp = 1;
		k = 0;
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= d;
		s_axi_awvalid_in <= 1'h1;
		s_axi_wvalid_in <= 1'h1;
		s_axi_bready_in <= 1'h1;
		do begin
			@(posedge clk_in);
			k++;
			if (ap && s_axi_awready_out) s_axi_awvalid_in <= 1'h0;
			if (ap && s_axi_awready_out) ap = 0;
			if (wp && s_axi_wready_out) s_axi_wvalid_in <= 1'h0;
			if (wp && s_axi_wready_out) wp = 0;
		end while (!s_axi_bvalid_out && k < 60);
		s_axi_bready_in <= 1'h0;
		tmo(k);
		@(posedge clk_in);
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] d,
		input logic [1:0] er);
		bit ap;
		int k;
		rq.push_back({er, d});
		ap = 1;
		k = 0;
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'h1;
		s_axi_rready_in <= 1'h1;
		do begin
			@(posedge clk_in);
			k++;
			if (ap && s_axi_arready_out) s_axi_arvalid_in <= 1'h0;
			if (ap && s_axi_arready_out) ap = 0;
		end while (!s_axi_rvalid_out && k < 60);
		s_axi_rready_in <= 1'h0;
		tmo(k);
		@(posedge clk_in);
	endtask
	// Stop the stream, keep the link off, then load a new setup.
	task automatic setup(input logic [5:0] v);
		run_reg <= 1'h0;
		repeat (4) @(posedge clk_in);
		wr({`IDX_LINK_CTRL, 2'h0}, 32'h0, 2'h0);
		wr({`IDX_FILTER_CFG, 2'h0}, {26'h0, v}, 2'h0);
		rd({`IDX_FILTER_CFG, 2'h0}, {26'h0, v}, 2'h0);
		rd({`IDX_STATUS, 2'h0}, {30'h0, v[5], v[1:0] == 2'h2},
			2'h0);
		mode = v[1:0];
		// A side weight of seven is held at six.
		scw = (v[4:2] > 3'h6) ? 6 : v[4:2];
		merge = v[5];
		selb = 0;
	endtask
	// Expected output for the newest delay-line contents.
	function automatic logic [11:0] ex();
		longint s;
		if (mode != 2) return h[0][11:0];
		s = (cs[0] * h[1] + cs[1] * h[2] + cs[2] * h[3]) <<< scw;
		s = (s + cs[3] * h[4]) >>> 16;
		if (s > 2047) return 12'h7ff;
		if (s < -2048) return 12'h800;
		return s[11:0];
	endfunction
	// Note each taken sample and the output it must produce.
	always @(posedge clk_in) begin
		if (nrst_in && sample_valid_in) begin
			for (int i = 8; i > 0; i--) h[i] = h[i - 1];
			h[0] = (merge && selb) ? longint'($signed(sample_b_in))
				: longint'($signed(sample_a_in));
			selb = merge ? !selb : 1'b0;
			sq.push_back(ex());
		end
	end
	// Compare every answer that appears with the oldest note.
	always @(posedge clk_in) begin
		if (nrst_in && s_axi_bvalid_out && s_axi_bready_in)
			chk("bresp", s_axi_bresp_out, bq.pop_front());
		if (nrst_in && s_axi_rvalid_out && s_axi_rready_in) begin
			re = rq.pop_front();
			chk("rdata", s_axi_rdata_out, re[31:0]);
			chk("rresp", s_axi_rresp_out, re[33:32]);
		end
		if (nrst_in && filt_valid_out)
			chk("filt", filt_sample_out, sq.pop_front());
	end
	// Main sequence.
	initial begin
		repeat (12) @(posedge clk_in);
		nrst_in <= 1'h1;
		@(posedge clk_in);
		for (int i = 0; i < 4; i++) begin
			rd(ad[i], 32'h0, 2'h0);
			wr(ad[i], 32'hffffffff, 2'h0);
			rd(ad[i], i < 3 ? 32'hffff : 32'hffffff, 2'h0);
			wr(ad[i], cv[i], 2'h0);
			rd(ad[i], cv[i], 2'h0);
		end
		rd(16'h106c, 32'h0, 2'h2);
		wr(16'h1069, 32'h5, 2'h2);
		rd(ad[0], cv[0], 2'h0);
		s_axi_wstrb_in <= 4'h2;
		wr(ad[0], 32'h0000a5ff, 2'h0);
		s_axi_wstrb_in <= 4'hf;
		rd(ad[0], 32'ha500, 2'h0);
		wr(ad[0], cv[0], 2'h0);
		wr({`IDX_STATUS, 2'h0}, 32'h3, 2'h0);
		wr({`IDX_LINK_CTRL, 2'h0}, 32'h1, 2'h0);
		chk("link", serial_link_enable_out, 32'h1);
		rd({`IDX_LINK_CTRL, 2'h0}, 32'h1, 2'h0);
		$display("test registers done");
		foreach (cf[i]) begin
			setup(cf[i]);
			run_reg <= 1'h1;
			repeat (40) @(posedge clk_in);
			$display("test stream %0d done", i);
		end
		setup(6'h00);
		chk("pending", sq.size(), 32'h0);
		test_done;
	end
endmodule // tb_top
bind fir_coefficient_taps_chan_a coef_monitor u_coef_monitor (.*);
